// *** rtl/async_sram_write_sequencer.sv ***
// Write-cycle sequencer for an asynchronous static RAM, with APB registers.
// Assumes the read engine is elsewhere and pulses readDone after each read.
`timescale 1ns/1ns
module async_sram_write_sequencer
    import sram_wr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wrReq,
    input  wire logic [19:0] wrAddress,
    input  wire logic [31:0] wrData,
    input  wire logic [3:0]  wrLaneSelN,
    output logic             wrReady,
    input  wire logic        readDone,
    output logic             chip_enable_n,
    output logic [3:0]       byte_lane_select_n,
    output logic [19:0]      ext_address,
    output logic [31:0]      ext_data_bus_out,
    output logic             ext_data_bus_oe,
    input  wire logic [31:0] ext_data_bus_in,
    output logic             write_strobe_n,
    output logic             output_enable_n
);
    seq_state_type state_q;      // Sequencer state
    seq_state_type state_d;
    logic [19:0]   address_q;    // Latched write address
    logic [31:0]   data_q;       // Latched write data
    logic [3:0]    lanes_q;      // Latched lane selects
    logic          dataOe_q;     // Data bus driven
    logic [31:0]   timingCfg;    // Space timing register
    logic [31:0]   seqCtrl;      // Variant and turnaround
    logic [31:0]   statusWord;   // Status view for software
    logic          load;         // Period counter reload
    logic [5:0]    loadValue;
    logic          lastCycle;    // Current period ends this cycle

    // Field views of the timing and control registers
    logic [3:0] wrSetup;
    logic [5:0] wrStrobe;
    logic [1:0] wrHold;
    logic [1:0] rdHold;
    logic [2:0] memKind;
    logic       variantB;
    logic [1:0] turnCycles;

    assign wrSetup    = timingCfg[WR_SETUP_MSB:WR_SETUP_LSB];
    assign wrStrobe   = timingCfg[WR_STROBE_MSB:WR_STROBE_LSB];
    assign wrHold     = timingCfg[WR_HOLD_MSB:WR_HOLD_LSB];
    assign rdHold     = timingCfg[RD_HOLD_MSB:RD_HOLD_LSB];
    assign memKind    = timingCfg[MEM_KIND_MSB:MEM_KIND_LSB];
    assign variantB   = seqCtrl[VARIANT_B_BIT];
    assign turnCycles = seqCtrl[TURN_MSB:TURN_LSB];

    // Register file
    apb_reg_slave u_regs (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .statusWord (statusWord),
        .timingCfg  (timingCfg),
        .seqCtrl    (seqCtrl)
    );

    // One counter times every period on clk_sys, the timing clock
    period_counter u_period (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .load      (load),
        .loadValue (loadValue),
        .lastCycle (lastCycle)
    );

    // Setup lengths: variant A first access is stretched to two
    logic [3:0] setupFirst;
    logic [3:0] setupNext;
    assign setupFirst = (!variantB && wrSetup < SETUP_MIN_FIRST_A) ? SETUP_MIN_FIRST_A :
                        (wrSetup < SETUP_MIN) ? SETUP_MIN : wrSetup;
    assign setupNext  = (wrSetup < SETUP_MIN) ? SETUP_MIN : wrSetup;

    // Only the 32-bit async kind is sequenced; anything else is refused
    logic kindOk;
    assign kindOk = (memKind == MEM_KIND_ASYNC32);

    // Last cycle of a write; zero strobe or hold means no such period
    logic writeDone;
    assign writeDone = lastCycle &&
                       ((state_q == ST_HOLD) ||
                        (state_q == ST_STROBE && wrHold == 2'h0) ||
                        (state_q == ST_SETUP && wrStrobe == 6'h00 && wrHold == 2'h0));

    // Request acceptance; a finished read is handled first
    logic idleTake;
    logic nextTake;
    logic readTake;
    logic releaseNow;
    assign readTake   = (state_q == ST_IDLE) && readDone;
    assign idleTake   = (state_q == ST_IDLE) && !readDone && wrReq && kindOk;
    assign nextTake   = writeDone && wrReq && kindOk;
    assign releaseNow = writeDone && !nextTake;
    assign wrReady    = idleTake || nextTake;

    // Where a write goes once its hold is over
    seq_state_type endState;
    logic [5:0]    endValue;
    logic [5:0]    tailLen;
    assign tailLen  = (wrHold != 2'h0) ? CE_TAIL_WITH_HOLD : CE_TAIL_NO_HOLD;
    assign endState = nextTake ? ST_SETUP :
                      (!variantB ? ST_CETAIL : ST_IDLE);
    assign endValue = nextTake ? {2'h0, setupNext} - 6'h01 : tailLen - 6'h01;

    // Read-side lengths: CE hold after read, or turnaround
    logic [5:0] readCeHold;
    assign readCeHold = READ_CE_HOLD_BASE - {4'h0, rdHold};

    // Next-state and period loading
    always_comb begin
        state_d   = state_q;
        load      = 1'b0;
        loadValue = 6'h00;
        case (state_q)
            ST_IDLE: begin
                if (readTake && variantB && turnCycles != 2'h0) begin
                    state_d   = ST_TURN;
                    load      = 1'b1;
                    loadValue = {4'h0, turnCycles} - 6'h01;
                end else if (readTake && !variantB) begin
                    state_d   = ST_RDHOLD;
                    load      = 1'b1;
                    loadValue = readCeHold - 6'h01;
                end else if (idleTake) begin
                    state_d   = ST_SETUP;
                    load      = 1'b1;
                    loadValue = {2'h0, setupFirst} - 6'h01;
                end
            end
            ST_TURN, ST_RDHOLD, ST_CETAIL: begin
                if (lastCycle) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SETUP: begin
                if (lastCycle && wrStrobe != 6'h00) begin
                    state_d   = ST_STROBE;
                    load      = 1'b1;
                    loadValue = wrStrobe - 6'h01;
                end else if (lastCycle && wrHold != 2'h0) begin
                    state_d   = ST_HOLD;
                    load      = 1'b1;
                    loadValue = {4'h0, wrHold} - 6'h01;
                end else if (lastCycle) begin
                    state_d   = endState;
                    load      = 1'b1;
                    loadValue = endValue;
                end
            end
            ST_STROBE: begin
                if (lastCycle && wrHold != 2'h0) begin
                    state_d   = ST_HOLD;
                    load      = 1'b1;
                    loadValue = {4'h0, wrHold} - 6'h01;
                end else if (lastCycle) begin
                    state_d   = endState;
                    load      = 1'b1;
                    loadValue = endValue;
                end
            end
            ST_HOLD: begin
                if (lastCycle) begin
                    state_d   = endState;
                    load      = 1'b1;
                    loadValue = endValue;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Address, lanes and data captured when a write is taken
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            address_q <= 20'h0_0000;
            data_q    <= 32'h0000_0000;
            lanes_q   <= 4'hF;
        end else if (wrReady) begin
            address_q <= wrAddress;
            data_q    <= wrData;
            lanes_q   <= wrLaneSelN;
        end
    end

    // Data drive: a following write keeps the bus, avoiding a glitch
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dataOe_q <= 1'b0;
        end else if (wrReady) begin
            dataOe_q <= 1'b1;
        end else if (releaseNow) begin
            dataOe_q <= 1'b0;
        end
    end

    // Pin decode from registered state
    logic ceActive;
    assign ceActive = (state_q == ST_SETUP) || (state_q == ST_STROBE) ||
                      (state_q == ST_HOLD) || (state_q == ST_CETAIL) ||
                      (state_q == ST_RDHOLD);
    assign chip_enable_n      = !ceActive;
    assign write_strobe_n     = (state_q != ST_STROBE);
    assign byte_lane_select_n = lanes_q;
    assign ext_address        = address_q;
    assign ext_data_bus_out   = data_q;
    assign ext_data_bus_oe    = dataOe_q;
    // Writes never open the memory's outputs
    assign output_enable_n    = 1'b1;

    // Status: busy, CE, data drive, last bus sample
    assign statusWord = {ext_data_bus_in[31:4], 1'b0, dataOe_q, ceActive,
                         state_q != ST_IDLE};

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    logic firstTakeA;
    logic setupLast;
    logic strobeLast;
    assign firstTakeA = idleTake && !variantB;
    assign setupLast  = (state_q == ST_SETUP) && lastCycle;
    assign strobeLast = (state_q == ST_STROBE) && lastCycle;

    setup_pins_a: assert property (
        $rose(state_q == ST_SETUP) |-> !chip_enable_n && ext_data_bus_oe &&
            byte_lane_select_n == $past(wrLaneSelN))
        else $error("setup entered without CE, lanes or data");
    first_setup_a: assert property (
        firstTakeA |=> (state_q == ST_SETUP) [*2])
        else $error("variant A first setup shorter than two");
    b_setup_a: assert property (
        (idleTake && variantB) |=> state_q == ST_SETUP)
        else $error("variant B write skipped setup");
    strobe_fall_a: assert property (
        $fell(write_strobe_n) |-> $past(setupLast))
        else $error("write strobe fell outside setup end");
    strobe_rise_a: assert property (
        $rose(write_strobe_n) |-> $past(strobeLast))
        else $error("write strobe rose outside strobe end");
    data_release_a: assert property (
        $fell(ext_data_bus_oe) |-> $past(releaseNow))
        else $error("data released at the wrong time");
    tail_hold_a: assert property (
        (releaseNow && !variantB && wrHold != 2'h0) |=>
            !chip_enable_n [*3] ##1 chip_enable_n)
        else $error("variant A CE tail not three cycles");
    tail_nohold_a: assert property (
        (releaseNow && !variantB && wrHold == 2'h0) |=>
            !chip_enable_n [*4] ##1 chip_enable_n)
        else $error("variant A CE tail not four cycles");
    b_ce_drop_a: assert property (
        (releaseNow && variantB) |=> chip_enable_n)
        else $error("variant B CE held after hold");
    turn_wait_a: assert property (
        (readTake && variantB && turnCycles != 2'h0) |=> !wrReady)
        else $error("write taken during turnaround");
    kind_gate_a: assert property (
        !kindOk |-> !wrReady)
        else $error("write taken for wrong memory kind");

    back_to_back_c: cover property (nextTake);
    tail_seen_c:    cover property (state_q == ST_CETAIL);
    turn_seen_c:    cover property (state_q == ST_TURN);
    rd_hold_c:      cover property (state_q == ST_RDHOLD);
endmodule

// *** pkg/sram_wr_pkg.sv ***
// Shared constants for the asynchronous SRAM write sequencer.
// Assumes one 25 MHz clock, which is also the timing clock of every period.
package sram_wr_pkg;

    // Register byte addresses on the APB bus
    localparam logic [7:0] ADDR_TIMING_CFG = 8'h00;
    localparam logic [7:0] ADDR_SEQ_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_SEQ_STATUS = 8'h08;

    // Reset values and writable-bit masks
    localparam logic [31:0] TIMING_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] TIMING_CFG_MASK  = 32'hFFFF_3F73;
    localparam logic [31:0] SEQ_CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] SEQ_CTRL_MASK    = 32'h0000_0031;

    // Timing register field positions
    localparam int WR_SETUP_MSB  = 31;
    localparam int WR_SETUP_LSB  = 28;
    localparam int WR_STROBE_MSB = 27;
    localparam int WR_STROBE_LSB = 22;
    localparam int WR_HOLD_MSB   = 21;
    localparam int WR_HOLD_LSB   = 20;
    localparam int RD_HOLD_MSB   = 1;
    localparam int RD_HOLD_LSB   = 0;
    localparam int MEM_KIND_MSB  = 6;
    localparam int MEM_KIND_LSB  = 4;

    // Control register field positions
    localparam int VARIANT_B_BIT = 0;
    localparam int TURN_MSB      = 5;
    localparam int TURN_LSB      = 4;

    // Memory kind code for 32-bit asynchronous memory
    localparam logic [2:0] MEM_KIND_ASYNC32 = 3'h2;

    // Cycle figures of the sequence
    localparam logic [3:0] SETUP_MIN_FIRST_A = 4'h2;
    localparam logic [3:0] SETUP_MIN         = 4'h1;
    localparam logic [5:0] CE_TAIL_WITH_HOLD = 6'h03;
    localparam logic [5:0] CE_TAIL_NO_HOLD   = 6'h04;
    localparam logic [5:0] READ_CE_HOLD_BASE = 6'h07;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_TURN, ST_RDHOLD, ST_SETUP, ST_STROBE, ST_HOLD, ST_CETAIL
    } seq_state_type;

endpackage

// *** rtl/period_counter.sv ***
// Down counter that times one setup, strobe, hold or overhead period.
// Assumes the loader gives the period length minus one.
`timescale 1ns/1ns
module period_counter
    import sram_wr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       load,
    input  wire logic [5:0] loadValue,
    output logic            lastCycle
);
    logic [5:0] count_q;  // Cycles left after this one
    logic [5:0] count_d;

    // Reload wins; otherwise count down and rest at zero
    assign count_d   = load ? loadValue : ((count_q == 6'h00) ? count_q : count_q - 6'h01);
    assign lastCycle = (count_q == 6'h00);

    // Count register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 6'h00;
        end else begin
            count_q <= count_d;
        end
    end
endmodule

// *** rtl/apb_reg_slave.sv ***
// APB slave holding the timing and control registers, plus a status view.
// Assumes an APB master; answers with no wait states, errors off the map.
`timescale 1ns/1ns
module apb_reg_slave
    import sram_wr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] statusWord,
    output logic [31:0]      timingCfg,
    output logic [31:0]      seqCtrl
);
    logic [31:0] timingCfg_q;  // Space timing configuration
    logic [31:0] seqCtrl_q;    // Variant and turnaround
    logic        hitCfg;
    logic        hitCtrl;
    logic        hitStatus;
    logic        access;
    logic        setupPhase;   // First cycle of a transfer
    logic [31:0] readMux;      // Word selected by the address
    logic [31:0] prdata_q;     // Read data, loaded in the setup phase

    // Address decode
    assign hitCfg    = (paddr == ADDR_TIMING_CFG);
    assign hitCtrl   = (paddr == ADDR_SEQ_CTRL);
    assign hitStatus = (paddr == ADDR_SEQ_STATUS);
    assign access    = psel && penable;

    // Zero wait states; unmapped addresses take an error
    assign pready  = 1'b1;
    assign pslverr = access && !(hitCfg || hitCtrl || hitStatus);

    // Read mux; reserved bits were masked at write time
    assign readMux    = hitCfg ? timingCfg_q :
                        hitCtrl ? seqCtrl_q :
                        hitStatus ? statusWord : 32'h0000_0000;
    assign setupPhase = psel && !penable;
    assign prdata     = prdata_q;

    // Read word captured at the setup edge, so it stands through the access phase
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata_q <= readMux;
        end
    end

    assign timingCfg = timingCfg_q;
    assign seqCtrl   = seqCtrl_q;

    // Writes land in the access phase only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            timingCfg_q <= TIMING_CFG_RESET;
            seqCtrl_q   <= SEQ_CTRL_RESET;
        end else if (access && pwrite) begin
            if (hitCfg) begin
                timingCfg_q <= pwdata & TIMING_CFG_MASK;
            end
            if (hitCtrl) begin
                seqCtrl_q <= pwdata & SEQ_CTRL_MASK;
            end
        end
    end
endmodule

// *** dv/sram_model.sv ***
// Behavioural asynchronous SRAM on the far side of the write sequencer.
// Assumes no clock of its own; a write lands as the write strobe rises.
`timescale 1ns/1ns
module sram_model (
    input  wire logic        chip_enable_n,
    input  wire logic [3:0]  byte_lane_select_n,
    input  wire logic [19:0] ext_address,
    input  wire logic        write_strobe_n,
    input  wire logic        output_enable_n,
    input  wire logic [31:0] busOut,
    input  wire logic        busOe,
    output logic [31:0]      busIn
);
    logic [31:0] mem [16];                    // Small store, low address bits only
    logic [31:0] lastVal = 32'h0000_0000;     // Last level seen on the shared bus
    logic        memDrive;                    // Memory drives its outputs

    assign memDrive = !chip_enable_n && !output_enable_n;
    // No pull on the bus: once released it shows the inverse of its last level
    assign busIn = busOe ? busOut : (memDrive ? mem[ext_address[3:0]] : ~lastVal);

    // Remember what the controller last drove
    always @(busOut or busOe) begin
        if (busOe) begin
            lastVal = busOut;
        end
    end

    // Data is taken at the strobe's rising edge, so early release corrupts it
    always @(posedge write_strobe_n) begin
        if (!chip_enable_n) begin
            for (int i = 0; i < 4; i++) begin
                if (!byte_lane_select_n[i]) begin
                    mem[ext_address[3:0]][i*8 +: 8] = busIn[i*8 +: 8];
                end
            end
        end
    end
endmodule

// *** dv/tb_async_sram_write_sequencer.sv ***
// Self-checking bench for the asynchronous SRAM write sequencer.
// Assumes sram_model on the far side and the register map of the package.
`timescale 1ns/1ns
module tb_async_sram_write_sequencer;
    import sram_wr_pkg::*;
    logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, wrReq;
    logic        wrReady, readDone, chip_enable_n, ext_data_bus_oe, write_strobe_n;
    logic        output_enable_n, mon, wePrev, erv;
    logic [3:0]  wrLaneSelN, byte_lane_select_n;
    logic [7:0]  paddr, ceCnt, weCnt, oeCnt, weFalls, setCnt;
    logic [19:0] wrAddress, ext_address;
    logic [31:0] pwdata, prdata, wrData, ext_data_bus_out, ext_data_bus_in, rdv;
    logic [56:0] snap;                        // Pins in the first cycle with CE low
    int          errTotal, checksDone;

    async_sram_write_sequencer DUT (
        .clk_sys (clk_sys), .reset_n (reset_n), .psel (psel), .penable (penable),
        .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata),
        .pready (pready), .pslverr (pslverr), .wrReq (wrReq), .wrAddress (wrAddress),
        .wrData (wrData), .wrLaneSelN (wrLaneSelN), .wrReady (wrReady),
        .readDone (readDone), .chip_enable_n (chip_enable_n),
        .byte_lane_select_n (byte_lane_select_n), .ext_address (ext_address),
        .ext_data_bus_out (ext_data_bus_out), .ext_data_bus_oe (ext_data_bus_oe),
        .ext_data_bus_in (ext_data_bus_in), .write_strobe_n (write_strobe_n),
        .output_enable_n (output_enable_n)
    );
    sram_model model (
        .chip_enable_n      (chip_enable_n),
        .byte_lane_select_n (byte_lane_select_n),
        .ext_address        (ext_address),
        .write_strobe_n     (write_strobe_n),
        .output_enable_n    (output_enable_n),
        .busOut             (ext_data_bus_out),
        .busOe              (ext_data_bus_oe),
        .busIn              (ext_data_bus_in)
    );

    // 25 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Per-cycle tally of pin levels while a write is watched
    always @(negedge clk_sys) begin
        if (mon) begin
            if (!chip_enable_n && write_strobe_n && weFalls == 8'h00) setCnt++;
            if (!chip_enable_n) ceCnt++;
            if (!write_strobe_n) weCnt++;
            if (ext_data_bus_oe) oeCnt++;
            if (!write_strobe_n && wePrev) weFalls++;
            if (!chip_enable_n && ceCnt == 8'h01) snap = {byte_lane_select_n, ext_address,
                ext_data_bus_out, ext_data_bus_oe};
        end
        wePrev = write_strobe_n;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finalReport();
        if (errTotal == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        // Access lasts until pready is seen high; only the watchdog ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    // Timing word with kind 010; read setup and strobe left at zero
    function automatic logic [31:0] mkCfg(input logic [3:0] s, input logic [5:0] st,
                                          input logic [1:0] h, input logic [1:0] rh);
        return {s, st, h, 4'h0, 2'h0, 6'h00, 1'b0, MEM_KIND_ASYNC32, 2'h0, rh};
    endfunction

    // Timing reset value, writable masks, reserved bits and an unmapped address
    task automatic regTest();
        apb(1'b0, ADDR_TIMING_CFG, 32'h0000_0000);
        check("cfg reset", rdv, 32'h0000_0000);
        apb(1'b1, ADDR_TIMING_CFG, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_TIMING_CFG, 32'h0000_0000);
        check("cfg mask", rdv, 32'hFFFF_3F73);
        apb(1'b1, ADDR_SEQ_CTRL, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_SEQ_CTRL, 32'h0000_0000);
        check("ctrl mask", rdv, 32'h0000_0031);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        check("unmapped", {rdv[30:0], erv}, 32'h0000_0001);
    endtask

    // Wrong kind code: the request must never be taken
    task automatic refuseTest();
        int hits;
        apb(1'b1, ADDR_TIMING_CFG, 32'h1088_0000);
        wrReq <= 1'b1;
        hits = 0;
        repeat (8) begin
            @(negedge clk_sys);
            if (wrReady !== 1'b0) hits++;
        end
        @(posedge clk_sys);
        wrReq <= 1'b0;
        check("refused ready", hits, 0);
    endtask

    // Program timing, run n writes back to back, compare pin tallies
    task automatic runOne(input logic [31:0] cfg, input logic [31:0] ctrl, input int n,
                          input logic chkMem, input logic [7:0] eCe, eWe, eOe, eSet);
        int k;
        apb(1'b1, ADDR_TIMING_CFG, cfg);
        apb(1'b1, ADDR_SEQ_CTRL, ctrl);
        {ceCnt, weCnt, oeCnt, weFalls, setCnt} = '0;
        mon = 1'b1;
        for (int i = 0; i < n; i++) begin
            wrReq <= 1'b1;
            wrAddress <= 20'h0_0003 + 20'(i);
            wrData <= 32'hA5C3_0F10 + 32'(i);
            wrLaneSelN <= 4'h0;
            k = 0;
            do begin
                @(negedge clk_sys);
                k++;
            end while (wrReady !== 1'b1 && k < 40);
            check("ready", {31'h0, wrReady}, 32'h0000_0001);
            @(posedge clk_sys);
        end
        wrReq <= 1'b0;
        repeat (20) @(posedge clk_sys);
        mon = 1'b0;
        check("ce low cycles", ceCnt, eCe);
        check("strobe cycles", weCnt, eWe);
        check("drive cycles", oeCnt, eOe);
        check("setup cycles", setCnt, eSet);
        check("setup data", snap[32:1], 32'hA5C3_0F10);
        check("setup ctl", {7'h00, snap[56:33], snap[0]}, {7'h00, 24'h0_0003, 1'b1});
        check("read enable", {31'h0, output_enable_n}, 32'h0000_0001);
        if (chkMem) check("stored word", model.mem[3], 32'hA5C3_0F10);
    endtask

    // Read finished, write waiting: count blocked cycles and CE low cycles
    task automatic afterRead(input logic [31:0] cfg, input logic [31:0] ctrl,
                             input logic [7:0] eLow, input logic [7:0] eCe);
        logic [7:0] low, ce;
        apb(1'b1, ADDR_TIMING_CFG, cfg);
        apb(1'b1, ADDR_SEQ_CTRL, ctrl);
        @(posedge clk_sys);
        {readDone, wrReq} <= 2'b11;
        @(posedge clk_sys);
        readDone <= 1'b0;
        {low, ce} = '0;
        do begin
            @(negedge clk_sys);
            if (wrReady !== 1'b1) low++;
            if (!chip_enable_n) ce++;
        end while (wrReady !== 1'b1 && low < 40);
        @(posedge clk_sys);
        wrReq <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check("blocked cycles", low, eLow);
        check("read ce hold", ce, eCe);
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        errTotal++;
        finalReport();
    end

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, mon, readDone} = '0;
        {wrReq, wrAddress, wrData, errTotal, checksDone} = '0;
        wrLaneSelN = 4'hF;
        wePrev = 1'b1;
        reset_n = 1'b0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        regTest();
        refuseTest();
        runOne(mkCfg(4'h1, 6'h02, 2'h1, 2'h0), 32'h0000_0001, 1, 1'b1, 8'h04, 8'h02, 8'h04,
               8'h01);
        runOne(mkCfg(4'h0, 6'h01, 2'h0, 2'h0), 32'h0000_0001, 1, 1'b0, 8'h02, 8'h01, 8'h02,
               8'h01);
        runOne(mkCfg(4'h1, 6'h01, 2'h1, 2'h0), 32'h0000_0000, 1, 1'b1, 8'h07, 8'h01, 8'h04,
               8'h02);
        runOne(mkCfg(4'h1, 6'h01, 2'h0, 2'h0), 32'h0000_0000, 1, 1'b0, 8'h07, 8'h01, 8'h03,
               8'h02);
        runOne(mkCfg(4'h1, 6'h01, 2'h1, 2'h0), 32'h0000_0000, 2, 1'b1, 8'h0A, 8'h02, 8'h07,
               8'h02);
        afterRead(mkCfg(4'h1, 6'h02, 2'h1, 2'h0), 32'h0000_0021, 8'h02, 8'h00);
        afterRead(mkCfg(4'h1, 6'h02, 2'h1, 2'h1), 32'h0000_0000, 8'h06, 8'h06);
        finalReport();
    end
endmodule
